// [fracn_synth_divider_control_tb.sv]
// fracn_synth_divider_control_tb: self-checking bench of fsdc_core
// assumes: package, core, host model and checker compiled before it
`timescale 1ns/1ps
module fracn_synth_divider_control_tb;
   import fsdc_pkg::*;
   logic           i_core_clk = 1'h0, i_rst_n = 1'h0, i_extra_en_n = 1'h1;
   logic           i_direct_mode = 1'h0, i_dir_pre_en = 1'h0, i_mash_order_pick = 1'h0;
   logic           i_ref_in = 1'h0, i_vco_in = 1'h0, ref_ph = 1'h0;
   logic           i_ce = 1'h1, i_dither_sel = 1'h0;
   logic [R_W-1:0] i_dir_r = 6'h00;
   logic [M_W-1:0] i_dir_m = 9'h000;
   logic [A_W-1:0] i_dir_a = 4'h0;
   logic [K_W-1:0] i_dir_k = 18'h00000;
   logic [1:0]     vco_ph = 2'h0;
   wire logic      sclk, sdata, sload, xsel, up_n, dn_n, node, ld_o, ld_oe_n, mon, mp;
   int             seed, failures, comparisons, cyc, m, r, a;
   int             w_pump, w_oe, w_mon, w_bad, w_chg;
   // ==========================================
   // clocks: core 8 ns, vco every 6 cycles, reference every 4
   always #4 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      vco_ph <= (vco_ph == 2'h2) ? 2'h0 : vco_ph + 2'h1;
      if (vco_ph == 2'h2) i_vco_in <= ~i_vco_in;
      ref_ph <= ~ref_ph;
      if (ref_ph) i_ref_in <= ~i_ref_in;
   end
   fsdc_host host (.o_shift_clk(sclk), .o_shift_data(sdata), .o_load_strobe(sload),
      .o_extra_sel(xsel));
   fsdc_core dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
      .i_shift_clk(sclk), .i_shift_data(sdata), .i_load_strobe(sload), .i_extra_sel(xsel),
      .i_extra_en_n(i_extra_en_n), .i_direct_mode(i_direct_mode), .i_dir_r(i_dir_r),
      .i_dir_m(i_dir_m), .i_dir_a(i_dir_a), .i_dir_k(i_dir_k), .i_dir_pre_en(i_dir_pre_en),
      .i_dither_sel(i_dither_sel), .i_mash_order_pick(i_mash_order_pick), .i_ref_in(i_ref_in),
      .i_vco_in(i_vco_in), .o_pump_up_n(up_n), .o_pump_down_n(dn_n), .o_lock_node(node),
      .o_lock_indicator_o(ld_o), .o_lock_indicator_oe_n(ld_oe_n), .o_monitor(mon),
      .o_modulus_pick(mp));
   // ==========================================
   // helpers
   function automatic int rnd(input int n);
      return $unsigned($random(seed)) % n;
   endfunction : rnd
   function automatic logic [PRIM_W-1:0] setup_w(input logic [R_W-1:0] rv,
      input logic [M_W-1:0] mv, input logic pre, input logic [A_W-1:0] av);
      return {rv[5:4], mv[8:7], pre, mv[6:0], rv[3:0], av, ADDR_SETUP};
   endfunction : setup_w
   function automatic logic [PRIM_W-1:0] frac_w(input logic [K_W-1:0] k);
      return {k, 2'h0, ADDR_FRAC};
   endfunction : frac_w
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %0d seen %0d", name, exp, seen);
      end
   endtask : check
   task automatic end_sim();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // synchronous reset pulse, then a few cycles for the pin synchronisers
   task automatic reset_dut();
      @(posedge i_core_clk);
      i_rst_n <= 1'h0;
      repeat (2) @(posedge i_core_clk);
      i_rst_n <= 1'h1;
      repeat (4) @(posedge i_core_clk);
   endtask : reset_dut
   // cycles spanned by span periods after the 3rd monitor pulse
   task automatic period(input int span, output int c);
      int n, t0;
      logic pv;
      n = 0;
      c = 0;
      t0 = 0;
      pv = mon;
      for (int k = 0; k < 20000 && n < 3 + span; k++) begin
         @(posedge i_core_clk);
         #1;
         if (mon === 1'h1 && pv !== 1'h1) n++;
         if (mon === 1'h1 && pv !== 1'h1 && n == 3) t0 = k;
         if (mon === 1'h1 && pv !== 1'h1 && n == 3 + span) c = k - t0;
         pv = mon;
      end
      if (n < 3 + span) begin
         check("monitor_pulses", n, 3 + span);
         end_sim();
      end
   endtask : period
   // counts activity over n cycles
   task automatic watch(input int n);
      logic pm;
      {w_pump, w_oe, w_mon, w_bad, w_chg} = '0;
      pm = mp;
      repeat (n) begin
         @(posedge i_core_clk);
         #1;
         if (up_n !== 1'h1 || dn_n !== 1'h1) w_pump++;
         if (ld_oe_n !== 1'h1) w_oe++;
         if (mon !== 1'h0) w_mon++;
         if (mon !== mp && mon !== pm) w_bad++;
         if (mp !== pm) w_chg++;
         pm = mp;
      end
   endtask : watch
   // ==========================================
   // main sequence
   initial begin
      seed = 35804;
      repeat (2) @(posedge i_core_clk);
      i_rst_n <= 1'h1;
      repeat (10) @(posedge i_core_clk);
      i_extra_en_n <= 1'h0;
      // bypass: fraction and a ignored, fp every m+1 vco edges
      host.send_prim(frac_w(K_W'(rnd(262144))));
      host.send_extra(8'h04);
      for (int i = 0; i < 3; i++) begin
         m = (i == 0) ? 1 : 1 + rnd(12);
         host.send_prim(setup_w(R_W'(rnd(64)), M_W'(m), 1'h1, A_W'(rnd(16))));
         period(1, cyc);
         check("fp_bypass", cyc, (m + 1) * 6);
      end
      // prescaler: fp every 10(m+1)+a vco edges, modulator cleared by reset
      reset_dut();
      host.send_extra(8'h04);
      for (int i = 0; i < 3; i++) begin
         m = 1 + rnd(6);
         a = rnd(m + 2);
         @(posedge i_core_clk);
         i_mash_order_pick <= i[0];
         host.send_prim(setup_w(R_W'(rnd(64)), M_W'(m), 1'h0, A_W'(a)));
         host.send_prim(frac_w(18'h00000));
         period(1, cyc);
         check("fp_presc", cyc, (10 * (m + 1) + a) * 6);
      end
      // half fraction, m 9, a 4: four periods span 4(10(m+1)+a)+2 vco edges
      for (int i = 0; i < 2; i++) begin
         reset_dut();
         i_mash_order_pick <= ~i[0];
         i_dither_sel <= i[0];
         host.send_extra(8'h04);
         host.send_prim(setup_w(6'h00, 9'h009, 1'h0, 4'h4));
         host.send_prim(frac_w(18'h20000));
         period(4, cyc);
         check("fp_frac", cyc, (4 * 104 + 2) * 6);
      end
      // reference: fc every r+1 reference edges
      host.send_extra(8'h40);
      for (int i = 0; i < 3; i++) begin
         r = (i == 0) ? 0 : rnd(16);
         host.send_prim(setup_w(R_W'(r), 9'h005, 1'h1, 4'h0));
         period(1, cyc);
         check("fc_ref", cyc, (r + 1) * 4);
      end
      // direct pins replace serial values
      @(posedge i_core_clk);
      m = 1 + rnd(20);
      i_direct_mode <= 1'h1;
      i_dir_m <= M_W'(m);
      i_dir_r <= R_W'(rnd(64));
      i_dir_a <= A_W'(rnd(16));
      i_dir_k <= K_W'(rnd(262144));
      i_dir_pre_en <= 1'h1;
      host.send_extra(8'h04);
      period(1, cyc);
      check("fp_direct", cyc, (m + 1) * 6);
      @(posedge i_core_clk);
      i_direct_mode <= 1'h0;
      i_extra_en_n <= 1'h1;
      watch(100);
      watch(300);
      check("mon_disabled", w_mon, 0);
      @(posedge i_core_clk);
      i_extra_en_n <= 1'h0;
      // modulus pick mirrored on the monitor
      host.send_prim(setup_w(6'h00, 9'h002, 1'h0, 4'h2));
      host.send_extra(8'h20);
      watch(100);
      watch(600);
      check("mon_mod", w_bad, 0);
      check("mod_moves", w_chg != 0, 1'h1);
      // clock enable low freezes the divider chain
      i_ce <= 1'h0;
      repeat (2) @(posedge i_core_clk);
      watch(200);
      check("ce_freeze", w_chg, 0);
      i_ce <= 1'h1;
      // pumps pulse on a frequency error, lock pin follows
      host.send_prim(setup_w(6'h00, 9'h001, 1'h1, 4'h0));
      host.send_extra(8'h00);
      watch(400);
      check("pump_act", w_pump != 0, 1'h1);
      check("ld_low", w_oe != 0, 1'h1);
      host.send_extra(8'h80);
      watch(50);
      watch(400);
      check("ld_off", w_oe, 0);
      // power down stops pumps, serial port still loads
      host.send_extra(8'h08);
      watch(50);
      watch(400);
      check("pd_pump", w_pump, 0);
      host.send_extra(8'h40);
      period(1, cyc);
      check("pd_exit", cyc, 4);
      // another reset clears the extra control register
      reset_dut();
      watch(300);
      check("xc_reset", w_mon, 0);
      end_sim();
   end
endmodule : fracn_synth_divider_control_tb

// [fsdc_core.sv]
// fsdc_core: digital core of a fractional-n synthesizer
// serial load port, divider chain, sigma-delta modulator, phase detector
// assumes: every pin input is asynchronous to i_core_clk and much slower
// than it; the reference and vco inputs are sampled, so the model runs
// at reduced frequencies in simulation
`timescale 1ns/1ps
module fsdc_core (
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_ce,
   input  wire logic                        i_shift_clk,
   input  wire logic                        i_shift_data,
   input  wire logic                        i_load_strobe,
   input  wire logic                        i_extra_sel,
   input  wire logic                        i_extra_en_n,
   input  wire logic                        i_direct_mode,
   input  wire logic [fsdc_pkg::R_W-1:0]    i_dir_r,
   input  wire logic [fsdc_pkg::M_W-1:0]    i_dir_m,
   input  wire logic [fsdc_pkg::A_W-1:0]    i_dir_a,
   input  wire logic [fsdc_pkg::K_W-1:0]    i_dir_k,
   input  wire logic                        i_dir_pre_en,
   input  wire logic                        i_dither_sel,
   input  wire logic                        i_mash_order_pick,
   input  wire logic                        i_ref_in,
   input  wire logic                        i_vco_in,
   output logic                             o_pump_up_n,
   output logic                             o_pump_down_n,
   output logic                             o_lock_node,
   output logic                             o_lock_indicator_o,
   output logic                             o_lock_indicator_oe_n,
   output logic                             o_monitor,
   output logic                             o_modulus_pick
);
   import fsdc_pkg::*;

   // ==========================================================
   // types and state
   localparam int SY_W = 6;                        // sclk sdata swr ewr ref vco
   localparam int DP_W = R_W + M_W + A_W + K_W + 6; // slow pin inputs
   localparam int SY_SCLK = 5;
   localparam int SY_SDAT = 4;
   localparam int SY_SWR  = 3;
   localparam int SY_EWR  = 2;
   localparam int SY_REF  = 1;
   localparam int SY_VCO  = 0;

   typedef struct packed {
      logic [SY_W-1:0]        fs1;     // first synchroniser stage
      logic [SY_W-1:0]        fs2;
      logic [SY_W-1:0]        fs3;     // previous value for edges
      logic [DP_W-1:0]        ps1;
      logic [DP_W-1:0]        ps2;
      logic [PRIM_W-1:0]      prim;
      logic [XC_W-1:0]        xshift;
      logic [REG_W-1:0]       counter_setup;
      logic [REG_W-1:0]       fraction_word;
      logic [XC_W-1:0]        extra_control;
      logic [M_W-1:0]         act_m;
      logic [A_W-1:0]         act_a;
      logic                   act_pre;
      logic [K_W-1:0]         act_k;
      logic [R_W-1:0]         r_cnt;
      logic [M_W-1:0]         m_cnt;
      logic [PC_W-1:0]        p_cnt;
      logic [AL_W-1:0]        a_left;
      logic [ACC_W-1:0]       acc1;
      logic [ACC_W-1:0]       acc2;
      logic [ACC_W-1:0]       acc3;
      logic                   c2d;
      logic                   c3d;
      logic                   c3dd;
      logic                   tog;
      logic signed [DL_W-1:0] delta;
      logic                   up;
      logic                   dn;
      logic                   pump_up_n;
      logic                   pump_down_n;
      logic                   lock_node;
      logic                   ld_oe_n;
      logic                   monitor;
      logic                   modulus_pick;
   } fsdc_state_t;

   fsdc_state_t st;
   fsdc_state_t next_st;

   // ==========================================================
   // helpers
   // accumulator add with carry out
   function automatic logic [ACC_W:0] fsdc_acc_add(input logic [ACC_W-1:0] a,
                                                  input logic [ACC_W-1:0] b);
      fsdc_acc_add = {1'h0, a} + {1'h0, b};
   endfunction : fsdc_acc_add

   // modulus-high count for one period, clamped to the legal range
   function automatic logic [AL_W-1:0] fsdc_a_eff(input logic [A_W-1:0] a,
                                                 input logic signed [DL_W-1:0] d);
      logic signed [AL_W+1:0] s;
      s = $signed({3'h0, a}) + (AL_W+2)'(d);
      if (s < 0) begin
         fsdc_a_eff = '0;
      end else if (s > $signed({2'h0, AL_MAX})) begin
         fsdc_a_eff = AL_MAX;
      end else begin
         fsdc_a_eff = s[AL_W-1:0];
      end
   endfunction : fsdc_a_eff

   // prescaler phase reload for the cycle about to start
   function automatic logic [PC_W-1:0] fsdc_pc(input logic [AL_W-1:0] al);
      fsdc_pc = (al != '0) ? PC_DIV11 : PC_DIV10;
   endfunction : fsdc_pc

   // ==========================================================
   // next-state logic
   always_comb begin
      logic sclk_rise, swr_rise, ewr_fall, ref_rise, vco_rise;
      logic [R_W-1:0] d_r;
      logic [M_W-1:0] d_m;
      logic [A_W-1:0] d_a;
      logic [K_W-1:0] d_k;
      logic d_pre, d_dir, d_enh_n, d_dith, d_mash2, d_ewr, d_swr;
      logic [R_W-1:0] src_r;
      logic [M_W-1:0] src_m;
      logic [A_W-1:0] src_a;
      logic [K_W-1:0] src_k;
      logic src_pre;
      logic [XC_W-1:0] xc;
      logic fp, fc, reload;
      logic [ACC_W:0] s1, s2, s3;
      logic [AL_W-1:0] na;
      logic signed [DL_W-1:0] nd;
      logic nup, ndn;
      next_st = st;
      fp = 1'h0;
      fc = 1'h0;
      reload = 1'h0;
      s1 = '0;
      s2 = '0;
      s3 = '0;
      na = '0;
      nd = '0;

      // two-stage synchronisers for every pin, third stage for edges
      next_st.fs1 = {i_shift_clk, i_shift_data, i_load_strobe, i_extra_sel,
                     i_ref_in, i_vco_in};
      next_st.fs2 = st.fs1;
      next_st.fs3 = st.fs2;
      next_st.ps1 = {i_dir_r, i_dir_m, i_dir_a, i_dir_k, i_dir_pre_en,
                     i_direct_mode, i_extra_en_n, i_dither_sel, i_mash_order_pick,
                     1'h0};
      next_st.ps2 = st.ps1;
      {d_r, d_m, d_a, d_k, d_pre, d_dir, d_enh_n, d_dith, d_mash2} =
         st.ps2[DP_W-1:1];
      sclk_rise = st.fs2[SY_SCLK] & ~st.fs3[SY_SCLK];
      swr_rise  = st.fs2[SY_SWR] & ~st.fs3[SY_SWR];
      ewr_fall  = ~st.fs2[SY_EWR] & st.fs3[SY_EWR];
      ref_rise  = st.fs2[SY_REF] & ~st.fs3[SY_REF];
      vco_rise  = st.fs2[SY_VCO] & ~st.fs3[SY_VCO];
      d_ewr     = st.fs2[SY_EWR];
      d_swr     = st.fs2[SY_SWR];

      // serial shifting, never powered down
      if (sclk_rise && !d_swr) begin
         if (d_ewr) begin
            next_st.xshift = {st.xshift[XC_W-2:0], st.fs2[SY_SDAT]};
         end else begin
            next_st.prim = {st.prim[PRIM_W-2:0], st.fs2[SY_SDAT]};
         end
      end
      // load strobe: last-shifted bit selects the target register
      if (swr_rise) begin
         if (st.prim[PRIM_ADDR] == ADDR_SETUP) begin
            next_st.counter_setup = st.prim[PRIM_W-1:1];
         end else begin
            next_st.fraction_word = st.prim[PRIM_W-1:1];
         end
      end
      // double buffer copy on falling edge of the extra select
      if (ewr_fall) begin
         next_st.extra_control = st.xshift;
      end

      // effective extra controls, gated by the enable pin
      xc = d_enh_n ? '0 : st.extra_control;

      // value sources: pins in direct mode, else serial registers
      if (d_dir) begin
         src_r   = d_r;
         src_m   = d_m;
         src_a   = d_a;
         src_k   = d_k;
         src_pre = d_pre;
      end else begin
         src_r   = {st.counter_setup[CS_R5], st.counter_setup[CS_R4],
                    st.counter_setup[CS_R3:CS_R0]};
         src_m   = {st.counter_setup[CS_M8], st.counter_setup[CS_M7],
                    st.counter_setup[CS_M6:CS_M0]};
         src_a   = st.counter_setup[CS_A3:CS_A0];
         src_pre = st.counter_setup[CS_PRE];
         src_k   = st.fraction_word[FW_K_HI:FW_K_LO];
      end

      // continuous load keeps the active values tracking the sources
      if (xc[XC_CNTLOAD]) begin
         next_st.act_m   = src_m;
         next_st.act_a   = src_a;
         next_st.act_k   = src_k;
         next_st.act_pre = src_pre;
      end

      if (!xc[XC_PWRDN]) begin
         // reference divider: R+1 edges per output, zero passes through
         if (ref_rise) begin
            if (st.r_cnt == '0) begin
               fc = 1'h1;
               next_st.r_cnt = src_r;
            end else begin
               next_st.r_cnt = st.r_cnt - R_W'(1'h1);
            end
         end
         // main chain on each vco edge
         if (vco_rise) begin
            if (st.act_pre) begin
               // bypass: M+1 vco edges, no fraction
               if (st.m_cnt == '0) begin
                  fp = 1'h1;
                  reload = 1'h1;
               end else begin
                  next_st.m_cnt = st.m_cnt - M_W'(1'h1);
               end
            end else if (st.p_cnt != '0) begin
               next_st.p_cnt = st.p_cnt - PC_W'(1'h1);
            end else if (st.m_cnt == '0) begin
               fp = 1'h1;
               reload = 1'h1;
            end else begin
               // one prescaler cycle done: count M and A down
               na = st.a_left - AL_W'(st.a_left != '0);
               next_st.a_left = na;
               next_st.m_cnt  = st.m_cnt - M_W'(1'h1);
               next_st.p_cnt  = fsdc_pc(na);
            end
         end
      end

      // period end: step the modulator and reload the chain
      if (reload) begin
         if (!xc[XC_CNTLOAD]) begin
            next_st.act_m   = src_m;
            next_st.act_a   = src_a;
            next_st.act_k   = src_k;
            next_st.act_pre = src_pre;
         end
         nd = '0;
         if (!st.act_pre) begin
            // k fills the upper 18 bits, dither toggles the 19th lsb
            next_st.tog = d_dith ? ~st.tog : 1'h0;
            s1 = fsdc_acc_add(st.acc1, {st.act_k, st.tog});
            s2 = fsdc_acc_add(st.acc2, s1[ACC_W-1:0]);
            s3 = fsdc_acc_add(st.acc3, s2[ACC_W-1:0]);
            next_st.acc1 = s1[ACC_W-1:0];
            next_st.acc2 = s2[ACC_W-1:0];
            next_st.c2d  = s2[ACC_W];
            if (d_mash2) begin
               next_st.acc3 = '0;
               next_st.c3d  = 1'h0;
               next_st.c3dd = 1'h0;
               nd = DL_W'(s1[ACC_W]) + DL_W'(s2[ACC_W]) - DL_W'(st.c2d);
            end else begin
               next_st.acc3 = s3[ACC_W-1:0];
               next_st.c3d  = s3[ACC_W];
               next_st.c3dd = st.c3d;
               nd = DL_W'(s1[ACC_W]) + DL_W'(s2[ACC_W]) - DL_W'(st.c2d)
                  + DL_W'(s3[ACC_W]) - DL_W'({st.c3d, 1'h0}) + DL_W'(st.c3dd);
            end
         end
         next_st.delta  = nd;
         // the new period uses the freshly loaded values
         next_st.m_cnt  = next_st.act_m;
         next_st.a_left = next_st.act_pre ? '0 : fsdc_a_eff(next_st.act_a, nd);
         next_st.p_cnt  = next_st.act_pre ? '0 : fsdc_pc(next_st.a_left);
      end else if (xc[XC_CNTLOAD] && st.m_cnt > src_m) begin
         next_st.m_cnt = src_m;
      end

      // phase detector: first edge raises its flag, the second clears both
      nup = st.up | fc;
      ndn = st.dn | fp;
      if (nup && ndn) begin
         nup = 1'h0;
         ndn = 1'h0;
      end
      if (xc[XC_PWRDN]) begin
         nup = 1'h0;
         ndn = 1'h0;
      end
      next_st.up          = nup;
      next_st.dn          = ndn;
      next_st.pump_up_n   = ~nup;
      next_st.pump_down_n = ~ndn;
      // lock node and open-drain indicator
      next_st.lock_node   = ~(~nup & ~ndn);
      next_st.ld_oe_n     = xc[XC_LD_OFF] | (~nup & ~ndn);
      next_st.modulus_pick = (next_st.a_left != '0) && !next_st.act_pre;

      // monitor output mux
      next_st.monitor = (xc[XC_FP_OUT] & fp) | (xc[XC_FC_OUT] & fc)
                      | (xc[XC_MOD_OUT] & next_st.modulus_pick);
   end

   // ==========================================================
   // state register
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st               <= '0;
         st.counter_setup <= REG_RST;
         st.fraction_word <= REG_RST;
         st.extra_control <= XC_RST;
         st.pump_up_n     <= 1'h1;
         st.pump_down_n   <= 1'h1;
         st.ld_oe_n       <= 1'h1;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs straight from state, lock data pin tied low
   assign o_pump_up_n           = st.pump_up_n;
   assign o_pump_down_n         = st.pump_down_n;
   assign o_lock_node           = st.lock_node;
   assign o_lock_indicator_o    = 1'h0;       // open drain only pulls low
   assign o_lock_indicator_oe_n = st.ld_oe_n;
   assign o_monitor             = st.monitor;
   assign o_modulus_pick        = st.modulus_pick;
endmodule : fsdc_core

// [fsdc_core_sva.sv]
// fsdc_core_sva: port checks of the divider core
// assumes: bound into fsdc_core, one core clock domain
`timescale 1ns/1ps
module fsdc_core_sva (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_ref_in,
   input wire logic i_vco_in,
   input wire logic o_pump_up_n,
   input wire logic o_pump_down_n,
   input wire logic o_lock_node,
   input wire logic o_lock_indicator_o,
   input wire logic o_lock_indicator_oe_n,
   input wire logic o_monitor,
   input wire logic o_modulus_pick
);
   logic [3:0] ref_q, vco_q;
   logic       ref_d, vco_d;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // ==========================================
   // cycles since each pin input last moved
   always_ff @(posedge i_core_clk) begin
      ref_d <= i_ref_in;
      vco_d <= i_vco_in;
      ref_q <= (!i_rst_n || i_ref_in != ref_d) ? 4'h0 : ref_q + {3'h0, ref_q != 4'hF};
      vco_q <= (!i_rst_n || i_vco_in != vco_d) ? 4'h0 : vco_q + {3'h0, vco_q != 4'hF};
   end
   // ==========================================
   // pump and lock relations
   sequence s_calm;
      $stable(o_pump_up_n) && $stable(o_pump_down_n) ##1
      $stable(o_pump_up_n) && $stable(o_pump_down_n);
   endsequence
   sequence s_pulse_end;
      ($rose(o_pump_up_n) || $rose(o_pump_down_n)) && o_pump_up_n && o_pump_down_n;
   endsequence
   property p_node_nand; s_calm |-> o_lock_node == !(o_pump_up_n && o_pump_down_n); endproperty
   a_node_nand: assert property (p_node_nand) else $error("lock node not nand of pumps");
   property p_one_pump; o_pump_up_n || o_pump_down_n; endproperty
   a_one_pump: assert property (p_one_pump) else $error("both pumps low");
   property p_ld_data; !o_lock_indicator_o; endproperty
   a_ld_data: assert property (p_ld_data) else $error("lock pin drives high");
   property p_ld_cause;
      !o_lock_indicator_oe_n |-> !(o_pump_up_n && o_pump_down_n && $past(o_pump_up_n)
         && $past(o_pump_down_n) && $past(o_pump_up_n, 2) && $past(o_pump_down_n, 2));
   endproperty
   a_ld_cause: assert property (p_ld_cause) else $error("lock pin low without pulse");
   property p_reset;
      disable iff (1'h0) !i_rst_n |=> o_pump_up_n && o_pump_down_n && !o_lock_node
         && o_lock_indicator_oe_n && !o_monitor && !o_modulus_pick;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not idle after reset");
   property p_mp_cause; $changed(o_modulus_pick) |-> vco_q < 4'h8; endproperty
   a_mp_cause: assert property (p_mp_cause) else $error("modulus moved without vco");
   property p_pump_cause;
      $fell(o_pump_up_n) || $fell(o_pump_down_n) |-> ref_q < 4'h8 || vco_q < 4'h8;
   endproperty
   a_pump_cause: assert property (p_pump_cause) else $error("pulse without input edge");
   property p_node_after; s_pulse_end ##1 (o_pump_up_n && o_pump_down_n) [*2] |-> !o_lock_node;
   endproperty
   a_node_after: assert property (p_node_after) else $error("lock node stuck high");
endmodule : fsdc_core_sva
bind fsdc_core fsdc_core_sva u_sva (
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ref_in(i_ref_in), .i_vco_in(i_vco_in),
   .o_pump_up_n(o_pump_up_n), .o_pump_down_n(o_pump_down_n), .o_lock_node(o_lock_node),
   .o_lock_indicator_o(o_lock_indicator_o), .o_lock_indicator_oe_n(o_lock_indicator_oe_n),
   .o_monitor(o_monitor), .o_modulus_pick(o_modulus_pick));

// [fsdc_host.sv]
// fsdc_host: host model driving the four-wire serial load port
// assumes: shift clock period of 125 ns, idle data pin pulled low
`timescale 1ns/1ps
module fsdc_host (
   output logic o_shift_clk,
   output logic o_shift_data,
   output logic o_load_strobe,
   output logic o_extra_sel
);
   localparam realtime HALF = 62.5;
   // ==========================================
   // idle levels: clock stands low between frames
   initial begin
      o_shift_clk   = 1'h0;
      o_shift_data  = 1'h0;
      o_load_strobe = 1'h0;
      o_extra_sel   = 1'h0;
   end
   // one bit, set while clock low, taken on the rising edge
   task automatic shift_bit(input logic b);
      o_shift_data = b;
      #HALF o_shift_clk = 1'h1;
      #HALF o_shift_clk = 1'h0;
   endtask : shift_bit
   // 21-bit word msb first, then a load strobe pulse
   task automatic send_prim(input logic [20:0] w);
      for (int i = 20; i >= 0; i--) shift_bit(w[i]);
      #HALF o_shift_data = 1'h0;
      o_load_strobe = 1'h1;
      #(2*HALF) o_load_strobe = 1'h0;
      #HALF;
   endtask : send_prim
   // 8-bit word with select high, copied when select falls
   task automatic send_extra(input logic [7:0] x);
      o_extra_sel = 1'h1;
      #HALF;
      for (int i = 7; i >= 0; i--) shift_bit(x[i]);
      #HALF o_shift_data = 1'h0;
      o_extra_sel = 1'h0;
      #(2*HALF);
   endtask : send_extra
endmodule : fsdc_host

// [fsdc_pkg.sv]
// fsdc_pkg: constants and field layouts of the synthesizer divider core
// assumes: included before fsdc_core, no other dependencies
package fsdc_pkg;
   // ==========================================================
   // widths
   localparam int PRIM_W  = 21;    // serial primary shift register
   localparam int REG_W   = 20;    // counter setup and fraction word
   localparam int XC_W    = 8;     // extra control register
   localparam int M_W     = 9;
   localparam int R_W     = 6;
   localparam int A_W     = 4;
   localparam int K_W     = 18;
   localparam int ACC_W   = 19;    // accumulator incl. toggling lsb
   localparam int AL_W    = 5;     // modulus-high cycle count
   localparam int PC_W    = 4;     // prescaler phase counter
   localparam int DL_W    = 4;     // signed modulator step
   // ==========================================================
   // counter setup field positions (msb shifted first)
   localparam int CS_R5   = 19;
   localparam int CS_R4   = 18;
   localparam int CS_M8   = 17;
   localparam int CS_M7   = 16;
   localparam int CS_PRE  = 15;
   localparam int CS_M6   = 14;
   localparam int CS_M0   = 8;
   localparam int CS_R3   = 7;
   localparam int CS_R0   = 4;
   localparam int CS_A3   = 3;
   localparam int CS_A0   = 0;
   // fraction word field: fraction bits 17..0 on top, two reserved below
   localparam int FW_K_LO = 2;
   localparam int FW_K_HI = 19;
   // address bit of the primary register and its codes
   localparam int PRIM_ADDR = 0;
   localparam logic ADDR_SETUP = 1'h0;
   localparam logic ADDR_FRAC  = 1'h1;
   // ==========================================================
   // extra control bit positions
   localparam int XC_FP_OUT  = 2;
   localparam int XC_PWRDN   = 3;
   localparam int XC_CNTLOAD = 4;
   localparam int XC_MOD_OUT = 5;
   localparam int XC_FC_OUT  = 6;
   localparam int XC_LD_OFF  = 7;
   // ==========================================================
   // prescaler phase reload values (divide by 11 or 10)
   localparam logic [PC_W-1:0] PC_DIV11 = 4'hA;
   localparam logic [PC_W-1:0] PC_DIV10 = 4'h9;
   localparam logic [AL_W-1:0] AL_MAX   = 5'h0F;
   // reset values
   localparam logic [REG_W-1:0] REG_RST = 20'h00000;
   localparam logic [XC_W-1:0]  XC_RST  = 8'h00;
endpackage : fsdc_pkg
